// File: rtl/gec_pkg.sv
package gec_pkg;

    // register map
    localparam logic [7:0] GEC_GAIN_DRIVE_WAIT_OFS = 8'h00;
    localparam logic [7:0] GEC_CFG_RST             = 8'h00;

    // field positions
    localparam int GEC_ENTRY_ALWAYS_BIT = 7;
    localparam int GEC_GAIN_LSB         = 5;
    localparam int GEC_LED_LSB          = 3;
    localparam int GEC_WAIT_LSB         = 0;

    // consecutive gesture ends needed for exit, per persistence code
    localparam logic [3:0] GEC_PERSIST_LIMIT [4] = '{4'h1, 4'h2, 4'h4, 4'h7};

    // wait time in units of 0.1 ms, per wait code
    localparam logic [8:0] GEC_WAIT_UNITS [8] = '{
        9'h000, 9'h01c, 9'h038, 9'h054, 9'h08c, 9'h0e0, 9'h134, 9'h188
    };

    // timing
    localparam int GEC_CLK_PERIOD_NS = 100;
    localparam int GEC_WAIT_UNIT_NS  = 100000;
    localparam int GEC_WAIT_UNIT_CYC = (GEC_WAIT_UNIT_NS + GEC_CLK_PERIOD_NS - 1)
                                       / GEC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        GEC_IDLE = 2'b00,
        GEC_WAIT = 2'b01,
        GEC_MEAS = 2'b10
    } gec_state_t;

endpackage

// File: rtl/gec_wait_timer.sv
`timescale 1ns/10ps

module gec_wait_timer #(
    parameter int UNIT_CYCLES = gec_pkg::GEC_WAIT_UNIT_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       start,
    input  wire logic [2:0] waitCode,
    // status
    output logic            done
);
    import gec_pkg::*;

    localparam int PW = $clog2(UNIT_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LOAD = PW'(UNIT_CYCLES - 1);

    typedef struct packed {
        logic          busy;
        logic [8:0]    units;
        logic [PW-1:0] pre;
        logic          done;
    } gec_timer_t;

    gec_timer_t st_r;
    gec_timer_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (start) begin
            st_nxt.units = GEC_WAIT_UNITS[waitCode];
            st_nxt.pre   = PRE_LOAD;
            st_nxt.busy  = (GEC_WAIT_UNITS[waitCode] != 9'h000);
            st_nxt.done  = (GEC_WAIT_UNITS[waitCode] == 9'h000);
        end else if (st_r.busy) begin
            if (st_r.pre == '0) begin
                if (st_r.units == 9'h001) begin
                    st_nxt.busy = 1'b0;
                    st_nxt.done = 1'b1;
                end else begin
                    st_nxt.units = st_r.units - 9'h001;
                    st_nxt.pre   = PRE_LOAD;
                end
            end else begin
                st_nxt.pre = st_r.pre - PW'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;

    // elapsed-time helper for checking
    logic [31:0] elapsed_r;
    logic [31:0] expect_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            elapsed_r <= 32'h0;
            expect_r  <= 32'h0;
        end else if (start) begin
            elapsed_r <= 32'h0;
            expect_r  <= 32'(GEC_WAIT_UNITS[waitCode]) * 32'(UNIT_CYCLES);
        end else begin
            elapsed_r <= elapsed_r + 32'h1;
        end
    end

    property p_wait_length;
        @(posedge clk) disable iff (rst)
        done |-> (elapsed_r == expect_r);
    endproperty
    a_wait_length: assert property (p_wait_length)
        else $error("wait time does not match the selected code");

endmodule

// File: rtl/gec_entry_exit.sv
`timescale 1ns/10ps

// Overview of operation
// - Consecutive gesture ends are counted and the gesture engine exits once the count reaches the persistence limit.
// - Persistence code 00, 01, 10, 11 means exit on the 1st, 2nd, 4th, 7th consecutive gesture end.
// - With gestures enabled and enter-always set, every proximity result, zero included, enters the gesture engine.
// - With enter-always clear, entry happens only when the proximity result meets the entry threshold.
// - The gain field selects photodiode gain 1x, 2x, 4x or 8x for codes 00 to 11.
// - The LED field selects drive strength full, half, quarter or eighth for codes 00 to 11.
// - Between detection cycles the engine waits in a low power state for the selected wait time.
// - Wait codes 000 to 111 give 0, 2.8, 5.6, 8.4, 14, 22.4, 30.8 and 39.2 ms.
// - A gesture end is found by comparing the unmasked directional channels with the exit level.
// - An exit level of zero stops self exit; only software clearing the active control or clearing gestureEnable leaves.
module gec_entry_exit #(
    parameter int WAIT_UNIT_CYCLES = gec_pkg::GEC_WAIT_UNIT_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // configuration register port
    input  wire logic        cfgWrEn,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [7:0]  cfgWrData,
    output logic      [7:0]  cfgRdData,
    // loose control bits
    input  wire logic        gestureEnable,
    input  wire logic        gestureActiveClear,
    input  wire logic [1:0]  gestureExitPersistence,
    input  wire logic [7:0]  gestureExitLevel,
    input  wire logic [7:0]  gestureEntryProximityThreshold,
    input  wire logic [3:0]  exitMask,
    // proximity result
    input  wire logic        proxValid,
    input  wire logic [7:0]  proximityResult,
    // detection cycle
    input  wire logic        cycleDone,
    input  wire logic [31:0] directionalChannels,
    output logic             cycleStart,
    output logic             gestureActive,
    output logic      [1:0]  gestureGain,
    output logic      [1:0]  gestureLedStrength
);
    import gec_pkg::*;

    typedef struct packed {
        gec_state_t state;
        logic       active;
        logic [2:0] endCnt;
        logic [7:0] cfg;
        logic [7:0] rd;
        logic       start;
        logic       timerStart;
    } gec_ctrl_t;

    gec_ctrl_t st_r;
    gec_ctrl_t st_nxt;

    logic       timerDone;
    logic       cfgHit;
    logic       entryOk;
    logic [3:0] below;
    logic       endNow;
    logic [3:0] endSum;
    logic [3:0] limit;
    logic       exitNow;

    gec_wait_timer #(
        .UNIT_CYCLES (WAIT_UNIT_CYCLES)
    ) u_wait (
        .clk      (clk),
        .rst      (rst),
        .start    (st_r.timerStart),
        .waitCode (st_r.cfg[GEC_WAIT_LSB +: 3]),
        .done     (timerDone)
    );

    assign cfgHit  = (cfgAddr == GEC_GAIN_DRIVE_WAIT_OFS);
    assign entryOk = gestureEnable && proxValid
                   && (st_r.cfg[GEC_ENTRY_ALWAYS_BIT]
                       || (proximityResult >= gestureEntryProximityThreshold));

    // a channel counts toward the end when masked out or below the exit level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            below[i] = exitMask[i]
                     || (directionalChannels[i*8 +: 8] < gestureExitLevel);
        end
    end

    assign endNow  = &below;
    assign endSum  = {1'b0, st_r.endCnt} + 4'h1;
    assign limit   = GEC_PERSIST_LIMIT[gestureExitPersistence];
    assign exitNow = endNow && (endSum >= limit)
                   && (gestureExitLevel != 8'h00);

    always_comb begin
        st_nxt            = st_r;
        st_nxt.start      = 1'b0;
        st_nxt.timerStart = 1'b0;
        st_nxt.rd         = cfgHit ? st_r.cfg : 8'h00;
        if (cfgWrEn && cfgHit) begin
            st_nxt.cfg = cfgWrData;
        end
        if (gestureActiveClear || !gestureEnable) begin
            st_nxt.state  = GEC_IDLE;
            st_nxt.active = 1'b0;
            st_nxt.endCnt = 3'h0;
        end else begin
            unique case (st_r.state)
                GEC_IDLE: begin
                    if (entryOk) begin
                        st_nxt.state  = GEC_MEAS;
                        st_nxt.active = 1'b1;
                        st_nxt.endCnt = 3'h0;
                        st_nxt.start  = 1'b1;
                    end
                end
                GEC_MEAS: begin
                    if (cycleDone) begin
                        if (exitNow) begin
                            st_nxt.state  = GEC_IDLE;
                            st_nxt.active = 1'b0;
                            st_nxt.endCnt = 3'h0;
                        end else begin
                            st_nxt.state      = GEC_WAIT;
                            st_nxt.timerStart = 1'b1;
                            if (!endNow) begin
                                st_nxt.endCnt = 3'h0;
                            end else if (st_r.endCnt != 3'h7) begin
                                st_nxt.endCnt = endSum[2:0];
                            end
                        end
                    end
                end
                GEC_WAIT: begin
                    if (timerDone) begin
                        st_nxt.state = GEC_MEAS;
                        st_nxt.start = 1'b1;
                    end
                end
                default: begin
                    st_nxt.state  = GEC_IDLE;
                    st_nxt.active = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r       <= '0;
            st_r.state <= GEC_IDLE;
            st_r.cfg   <= GEC_CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfgRdData          = st_r.rd;
    assign cycleStart         = st_r.start;
    assign gestureActive      = st_r.active;
    assign gestureGain        = st_r.cfg[GEC_GAIN_LSB +: 2];
    assign gestureLedStrength = st_r.cfg[GEC_LED_LSB +: 2];

    property p_exit_on_limit;
        @(posedge clk) disable iff (rst)
        (st_r.state == GEC_MEAS && cycleDone && endNow && endSum >= limit
         && gestureExitLevel != 8'h00 && gestureEnable && !gestureActiveClear)
        |=> (!gestureActive && st_r.state == GEC_IDLE);
    endproperty
    a_exit_on_limit: assert property (p_exit_on_limit)
        else $error("engine did not exit at persistence limit");

    property p_exit_count;
        @(posedge clk) disable iff (rst)
        ($fell(gestureActive) && $past(gestureEnable) && !$past(gestureActiveClear))
        |-> ($past(endSum) >= $past(limit) && $past(endNow) && $past(cycleDone));
    endproperty
    a_exit_count: assert property (p_exit_count)
        else $error("engine exited before enough gesture ends");

    property p_enter_always;
        @(posedge clk) disable iff (rst)
        (st_r.state == GEC_IDLE && gestureEnable && proxValid && !gestureActiveClear
         && st_r.cfg[GEC_ENTRY_ALWAYS_BIT])
        |=> (gestureActive && cycleStart);
    endproperty
    a_enter_always: assert property (p_enter_always)
        else $error("enter-always did not enter the gesture engine");

    property p_enter_threshold;
        @(posedge clk) disable iff (rst)
        (st_r.state == GEC_IDLE && !st_r.cfg[GEC_ENTRY_ALWAYS_BIT]
         && proximityResult < gestureEntryProximityThreshold)
        |=> !gestureActive;
    endproperty
    a_enter_threshold: assert property (p_enter_threshold)
        else $error("entry below threshold");

    property p_gain_field;
        @(posedge clk) disable iff (rst)
        (cfgWrEn && cfgHit) |=> (gestureGain == $past(cfgWrData[GEC_GAIN_LSB +: 2]));
    endproperty
    a_gain_field: assert property (p_gain_field)
        else $error("gain output does not follow the written field");

    property p_led_field;
        @(posedge clk) disable iff (rst)
        (cfgWrEn && cfgHit) |=> (gestureLedStrength == $past(cfgWrData[GEC_LED_LSB +: 2]));
    endproperty
    a_led_field: assert property (p_led_field)
        else $error("led strength does not follow the written field");

    property p_wait_between;
        @(posedge clk) disable iff (rst)
        (cycleStart && $past(st_r.state) == GEC_WAIT) |-> $past(timerDone);
    endproperty
    a_wait_between: assert property (p_wait_between)
        else $error("detection cycle started before wait ended");

    property p_no_self_exit;
        @(posedge clk) disable iff (rst)
        (gestureActive && gestureExitLevel == 8'h00 && gestureEnable && !gestureActiveClear)
        |=> gestureActive;
    endproperty
    a_no_self_exit: assert property (p_no_self_exit)
        else $error("engine left with zero exit level");

    property p_count_clear;
        @(posedge clk) disable iff (rst)
        ($rose(gestureActive) || (st_r.state == GEC_MEAS && cycleDone && !endNow))
        |-> ##[0:1] (st_r.endCnt == 3'h0);
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("gesture end counter not cleared");

endmodule

// File: tb/gec_front_model.sv
`timescale 1ns/10ps

module gec_front_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // detection request and answer
    input  wire logic        cycleStart,
    input  wire logic [3:0]  lag,
    input  wire logic [31:0] nextData,
    output logic             cycleDone,
    output logic      [31:0] directionalChannels
);
    logic [4:0] cnt;

    // channel data is only valid with cycleDone, otherwise it toggles
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 5'h00;
            cycleDone <= 1'b0;
            directionalChannels <= 32'h0;
        end else begin
            cycleDone <= 1'b0;
            directionalChannels <= ~directionalChannels;
            if (cycleStart) begin
                cnt <= {1'b0, lag} + 5'h01;
            end else if (cnt == 5'h01) begin
                cycleDone <= 1'b1;
                directionalChannels <= nextData;
                cnt <= 5'h00;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
    end
endmodule

// File: tb/gec_entry_exit_test.sv
`timescale 1ns/10ps

module gec_entry_exit_test;
    import gec_pkg::*;

`define CHK(nm, ex, got) check_count++; if ((got) !== (ex)) begin n_fail++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, got); end

    logic        clk, rst, cfgWrEn, gestureEnable, gestureActiveClear, proxValid;
    logic        cycleDone, cycleStart, gestureActive;
    logic [7:0]  cfgAddr, cfgWrData, cfgRdData, gestureExitLevel, proximityResult;
    logic [7:0]  gestureEntryProximityThreshold;
    logic [1:0]  gestureExitPersistence, gestureGain, gestureLedStrength;
    logic [3:0]  exitMask, lag;
    logic [31:0] directionalChannels, nextData;
    int          n_fail, check_count, cycleCount;

    gec_entry_exit #(.WAIT_UNIT_CYCLES(2)) i_dut (.clk, .rst, .cfgWrEn, .cfgAddr,
        .cfgWrData, .cfgRdData, .gestureEnable, .gestureActiveClear,
        .gestureExitPersistence, .gestureExitLevel, .gestureEntryProximityThreshold,
        .exitMask, .proxValid, .proximityResult, .cycleDone, .directionalChannels,
        .cycleStart, .gestureActive, .gestureGain, .gestureLedStrength);

    gec_front_model i_front (.clk, .rst, .cycleStart, .lag, .nextData, .cycleDone,
        .directionalChannels);

    task automatic end_of_test;
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfgWrEn <= 1'b1;
        cfgAddr <= a;
        cfgWrData <= d;
        @(posedge clk);
        cfgWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cfgAddr <= a;
        @(posedge clk);
        #1 d = cfgRdData;
    endtask

    task automatic enter(input logic [7:0] v);
        @(posedge clk);
        proxValid <= 1'b1;
        proximityResult <= v;
        @(posedge clk);
        proxValid <= 1'b0;
        proximityResult <= ~v;
        #1;
    endtask

    task automatic drop;
        @(posedge clk);
        gestureActiveClear <= 1'b1;
        @(posedge clk);
        gestureActiveClear <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
    endtask

    // pat bit n set: the n-th detection cycle reports dEnd, else dNot
    task automatic runc(input int lim, input logic [7:0] pat, input logic [31:0] dEnd,
                        input logic [31:0] dNot, output int n);
        n = 0;
        nextData = pat[0] ? dEnd : dNot;
        for (int t = 0; t < lim && gestureActive === 1'b1; t++) begin
            @(posedge clk);
            #1;
            if (cycleDone === 1'b1) begin
                n++;
                nextData = pat[n[2:0]] ? dEnd : dNot;
                lag = n[0] ? 4'h9 : 4'h0;
            end
        end
    endtask

    task automatic t_reg;
        logic [7:0] d;
        rd(8'h00, d);
        `CHK("cfg reset", 8'h00, d)
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, {1'b0, i[1:0], ~i[1:0], 3'h5});
            #1;
            `CHK("gain", i[1:0], gestureGain)
            `CHK("led", ~i[1:0], gestureLedStrength)
        end
        wr(8'h01, 8'hff);
        rd(8'h00, d);
        `CHK("cfg", 8'h65, d)
        rd(8'h01, d);
        `CHK("unmapped", 8'h00, d)
    endtask

    task automatic t_entry;
        @(posedge clk);
        gestureExitLevel <= 8'h00;
        gestureEntryProximityThreshold <= 8'h40;
        wr(8'h00, 8'h00);
        enter(8'h3f);
        `CHK("below thr", 1'b0, gestureActive)
        enter(8'h40);
        `CHK("at thr", 1'b1, gestureActive)
        drop;
        gestureEntryProximityThreshold <= 8'hff;
        wr(8'h00, 8'h80);
        enter(8'h00);
        `CHK("always", 1'b1, gestureActive)
        drop;
    endtask

    task automatic t_persist;
        logic [3:0] lim [4] = '{4'h1, 4'h2, 4'h4, 4'h7};
        int n;
        for (int p = 0; p < 5; p++) begin
            @(posedge clk);
            gestureExitLevel <= 8'h10;
            gestureExitPersistence <= (p == 4) ? 2'h1 : p[1:0];
            enter(8'h00);
            runc(1000, (p == 4) ? 8'hfd : 8'hff, 32'h0f0f_0f0f, 32'h0f10_0f0f, n);
            `CHK("ends", (p == 4) ? 4'h4 : lim[p], n[3:0])
            `CHK("left", 1'b0, gestureActive)
        end
    endtask

    task automatic t_mask;
        int n;
        @(posedge clk);
        exitMask <= 4'h0;
        gestureExitPersistence <= 2'h0;
        enter(8'h00);
        runc(200, 8'hff, 32'h00ff_0000, 32'h0, n);
        `CHK("unmasked", 1'b1, gestureActive)
        // change the mask right after a cycle start, so no cycleDone is in flight
        for (int t = 0; t < 50 && cycleStart !== 1'b1; t++) begin
            @(posedge clk);
            #1;
        end
        exitMask <= 4'h4;
        runc(200, 8'hff, 32'h00ff_0000, 32'h0, n);
        `CHK("masked", 4'h1, n[3:0])
    endtask

    task automatic t_idle;
        int n;
        @(posedge clk);
        gestureExitLevel <= 8'h00;
        // all channels masked: every cycle is a gesture end, only the zero level holds
        exitMask <= 4'hf;
        enter(8'h00);
        runc(300, 8'hff, 32'h0, 32'h0, n);
        `CHK("no self exit", 1'b1, gestureActive)
        drop;
        `CHK("sw exit", 1'b0, gestureActive)
    endtask

    task automatic t_wait;
        int u [8] = '{0, 28, 56, 84, 140, 224, 308, 392};
        int d;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            gestureEnable <= 1'b0;
            repeat (12) @(posedge clk);
            wr(8'h00, {5'h10, k[2:0]});
            gestureEnable <= 1'b1;
            enter(8'h00);
            d = 0;
            while (cycleDone !== 1'b1 && d < 50) begin @(posedge clk); #1 d++; end
            d = 0;
            while (cycleStart !== 1'b1 && d < 1000) begin @(posedge clk); #1 d++; end
            `CHK("wait", 1'b1, (d >= 2 * u[k] + 2) && (d <= 2 * u[k] + 4))
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            n_fail++;
            end_of_test;
        end
    end

    initial begin
        {rst, gestureEnable} = 2'h3;
        {cfgWrEn, gestureActiveClear, proxValid} = 3'h0;
        {cfgAddr, cfgWrData, proximityResult, gestureExitLevel} = 32'h0;
        gestureEntryProximityThreshold = 8'hff;
        {gestureExitPersistence, exitMask, lag} = 10'h0;
        nextData = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reg;
        t_entry;
        t_persist;
        t_mask;
        t_idle;
        t_wait;
        end_of_test;
    end
endmodule
